// ---- otpps_defs.svh ----
// Purpose: constants of the programming sequencer (timing, pins, limits)
// Assumes: 250 MHz clock; times kept in ns, cycles derived from them
// Notes: least times round up to whole cycles
`ifndef OTPPS_DEFS_SVH
`define OTPPS_DEFS_SVH

`define OTPPS_CLK_PERIOD_NS 4
`define OTPPS_ADDR_W 18
`define OTPPS_DATA_W 8
`define OTPPS_ADDR_LAST 18'h3FFFF
`define OTPPS_MAX_PULSES 4'hA
`define OTPPS_TIMER_W 15
`define OTPPS_FIFO_DEPTH 4

// times, as printed
`define OTPPS_T_ADDR_SETUP_NS 2000
`define OTPPS_T_DATA_HOLD_NS 2000
`define OTPPS_T_SUPPLY_SETUP_NS 2000
`define OTPPS_T_PULSE_NS 100000
`define OTPPS_T_DATA_VALID_NS 150
`define OTPPS_T_OUT_FLOAT_NS 130

`define OTPPS_CYC(ns) (((ns) + `OTPPS_CLK_PERIOD_NS - 1) / `OTPPS_CLK_PERIOD_NS)
`define OTPPS_CYC_SETUP `OTPPS_CYC(`OTPPS_T_ADDR_SETUP_NS)
`define OTPPS_CYC_HOLD `OTPPS_CYC(`OTPPS_T_DATA_HOLD_NS)
`define OTPPS_CYC_SUPPLY `OTPPS_CYC(`OTPPS_T_SUPPLY_SETUP_NS)
`define OTPPS_CYC_PULSE `OTPPS_CYC(`OTPPS_T_PULSE_NS)
`define OTPPS_CYC_VALID `OTPPS_CYC(`OTPPS_T_DATA_VALID_NS)
`define OTPPS_CYC_FLOAT `OTPPS_CYC(`OTPPS_T_OUT_FLOAT_NS)

`endif

// ---- otpps_pkg.sv ----
// Purpose: types of the programming sequencer
// Assumes: nothing
// Notes: supply codes ask the board regulators for a level
package otpps_pkg;

    // off, 5.0 V (read and final check), programming level
    // (6.5 V core, 13.0 V programming rail)
    typedef enum logic [1:0] {
        OTPPS_SUP_OFF = 2'b00,
        OTPPS_SUP_READ = 2'b01,
        OTPPS_SUP_PROG = 2'b10
    } otpps_supply_type;

    typedef enum logic [3:0] {
        OTPPS_IDLE = 4'b0000,
        OTPPS_VCC_UP = 4'b0001,
        OTPPS_VPP_UP = 4'b0010,
        OTPPS_FETCH = 4'b0011,
        OTPPS_SETUP = 4'b0100,
        OTPPS_PULSE = 4'b0101,
        OTPPS_HOLD = 4'b0110,
        OTPPS_VFY_OE = 4'b0111,
        OTPPS_VFY_FLOAT = 4'b1000,
        OTPPS_NEXT = 4'b1001,
        OTPPS_VPP_DOWN = 4'b1010,
        OTPPS_VCC_DOWN = 4'b1011,
        OTPPS_FINISH = 4'b1100,
        OTPPS_ID_OE = 4'b1101,
        OTPPS_ID_FLOAT = 4'b1110
    } otpps_state_type;

    typedef enum logic [1:0] {
        OTPPS_PASS_NONE = 2'b00,
        OTPPS_PASS_PROG = 2'b01,
        OTPPS_PASS_VFY = 2'b10,
        OTPPS_PASS_FINAL = 2'b11
    } otpps_pass_type;

endpackage

// ---- otpps_stream_if.sv ----
// Purpose: byte stream between the source buffer and the sequencer
// Assumes: one clock, valid/ready handshake
// Notes: a word moves on a cycle with valid and ready both high
`timescale 1ns/1ns
interface otpps_stream_if #(
    parameter int WIDTH = 8
);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;

    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface

// ---- otpps_fifo.sv ----
// Purpose: small source-data buffer in front of the sequencer
// Assumes: DEPTH a power of two
// Notes: fill ready drops when full, so the feeder stalls
`timescale 1ns/1ns
module otpps_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic fill_valid_in,
    output logic fill_ready_out,
    input wire logic [WIDTH-1:0] fill_data_in,
    otpps_stream_if.source drain
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;

    wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire empty = (wr_q == rd_q);
    wire push = fill_valid_in && !full;
    wire pop = drain.ready && !empty;

    assign fill_ready_out = !full;
    assign drain.valid = !empty;
    assign drain.data = mem_q[rd_q[AW-1:0]];

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end

    // storage carries no reset; only pointers qualify it
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= fill_data_in;
        end
    end
endmodule

// ---- otpps_timer.sv ----
// Purpose: down-counter timing pulses, setups and waits
// Assumes: start is a one-cycle pulse
// Notes: expired rises after exactly cycles_in cycles from start
`timescale 1ns/1ns
`include "otpps_defs.svh"
module otpps_timer (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic start_in,
    input wire logic [`OTPPS_TIMER_W-1:0] cycles_in,
    output logic expired_out
);
    logic [`OTPPS_TIMER_W-1:0] cnt_q;

    assign expired_out = (cnt_q == '0);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= '0;
        end else if (start_in) begin
            cnt_q <= cycles_in - 1'b1;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule

// ---- otpps_sequencer.sv ----
// Purpose: programmer side of a byte-wide one-time-programmable memory
// Assumes: user streams source bytes in address order, once per pass
// Notes: supplies are requested by level code; regulators settle in 2 us
`timescale 1ns/1ns
`include "otpps_defs.svh"
module otpps_sequencer
    import otpps_pkg::*;
#(
    parameter int PULSE_CYCLES = `OTPPS_CYC_PULSE,
    parameter logic [`OTPPS_ADDR_W-1:0] ADDR_LAST = `OTPPS_ADDR_LAST
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic start_in,
    input wire logic id_start_in,
    input wire logic id_byte_select_in,
    input wire logic src_valid_in,
    output logic src_ready_out,
    input wire logic [`OTPPS_DATA_W-1:0] src_data_in,
    output otpps_pkg::otpps_pass_type pass_out,
    output logic busy_out,
    output logic done_out,
    output logic result_pass_out,
    output logic [`OTPPS_DATA_W-1:0] id_data_out,
    output otpps_pkg::otpps_supply_type vcc_level_out,
    output otpps_pkg::otpps_supply_type vpp_level_out,
    output logic [`OTPPS_ADDR_W-1:0] addr_out,
    output logic id_high_voltage_line_out,
    output logic chip_select_n_out,
    output logic output_enable_n_out,
    output logic program_strobe_n_out,
    output logic [`OTPPS_DATA_W-1:0] data_o_out,
    output logic data_oe_out,
    input wire logic [`OTPPS_DATA_W-1:0] data_i_in
);
    import otpps_pkg::*;

    otpps_stream_if #(.WIDTH(`OTPPS_DATA_W)) src_if ();

    otpps_state_type state_q, state_d;
    otpps_pass_type pass_q, pass_d;
    otpps_supply_type vcc_q, vcc_d, vpp_q, vpp_d;
    logic [`OTPPS_ADDR_W-1:0] addr_q, addr_d;
    logic [3:0] pulses_q, pulses_d;
    logic [`OTPPS_DATA_W-1:0] byte_q;
    logic fail_q, fail_d;
    logic id_mode_q, id_mode_d;
    logic done_q, done_d;
    logic id_sel_q;
    logic [`OTPPS_DATA_W-1:0] id_data_q;
    logic ce_n_q, oe_n_q, pgm_n_q, dq_oe_q, hv_q;
    logic [`OTPPS_TIMER_W-1:0] wait_cycles;
    logic timer_done;

    otpps_fifo #(
        .WIDTH(`OTPPS_DATA_W),
        .DEPTH(`OTPPS_FIFO_DEPTH)
    ) u_fifo (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .fill_valid_in(src_valid_in),
        .fill_ready_out(src_ready_out),
        .fill_data_in(src_data_in),
        .drain(src_if.source)
    );

    wire state_change = (state_d != state_q);
    otpps_timer u_timer (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .start_in(state_change),
        .cycles_in(wait_cycles),
        .expired_out(timer_done)
    );

    wire at_last = (addr_q == ADDR_LAST);
    wire fetch_take = (state_q == OTPPS_FETCH) && src_if.valid;
    wire sample_now = timer_done &&
        ((state_q == OTPPS_VFY_OE) || (state_q == OTPPS_ID_OE));
    wire byte_match = (data_i_in == byte_q);
    wire pulses_used = (pulses_q >= `OTPPS_MAX_PULSES);
    logic match_q;

    assign src_if.ready = (state_q == OTPPS_FETCH);

    // wait length of the state being entered
    always_comb begin
        unique case (state_d)
            OTPPS_VCC_UP,
            OTPPS_VPP_UP,
            OTPPS_VPP_DOWN,
            OTPPS_VCC_DOWN: wait_cycles = `OTPPS_TIMER_W'(`OTPPS_CYC_SUPPLY);
            OTPPS_SETUP: wait_cycles = `OTPPS_TIMER_W'(`OTPPS_CYC_SETUP);
            OTPPS_PULSE: wait_cycles = `OTPPS_TIMER_W'(PULSE_CYCLES);
            OTPPS_HOLD: wait_cycles = `OTPPS_TIMER_W'(`OTPPS_CYC_HOLD);
            OTPPS_VFY_OE,
            OTPPS_ID_OE: wait_cycles = `OTPPS_TIMER_W'(`OTPPS_CYC_VALID);
            OTPPS_VFY_FLOAT,
            OTPPS_ID_FLOAT: wait_cycles = `OTPPS_TIMER_W'(`OTPPS_CYC_FLOAT);
            default: wait_cycles = `OTPPS_TIMER_W'(1);
        endcase
    end

    always_comb begin
        state_d = state_q;
        pass_d = pass_q;
        vcc_d = vcc_q;
        vpp_d = vpp_q;
        addr_d = addr_q;
        pulses_d = pulses_q;
        fail_d = fail_q;
        id_mode_d = id_mode_q;
        done_d = done_q;
        unique case (state_q)
            OTPPS_IDLE: begin
                if (start_in || id_start_in) begin
                    state_d = OTPPS_VCC_UP;
                    vcc_d = OTPPS_SUP_PROG;
                    id_mode_d = !start_in;
                    done_d = 1'b0;
                    fail_d = 1'b0;
                    pass_d = OTPPS_PASS_NONE;
                end
            end
            OTPPS_VCC_UP: begin
                if (timer_done && id_mode_q) begin
                    state_d = OTPPS_ID_OE;
                end else if (timer_done) begin
                    state_d = OTPPS_VPP_UP;
                    vpp_d = OTPPS_SUP_PROG;
                end
            end
            OTPPS_VPP_UP: begin
                if (timer_done) begin
                    state_d = OTPPS_FETCH;
                    addr_d = '0;
                    pass_d = OTPPS_PASS_PROG;
                end
            end
            OTPPS_FETCH: begin
                if (src_if.valid) begin
                    pulses_d = '0;
                    state_d = (pass_q == OTPPS_PASS_PROG) ? OTPPS_SETUP
                                                          : OTPPS_VFY_OE;
                end
            end
            OTPPS_SETUP: begin
                if (timer_done) begin
                    state_d = OTPPS_PULSE;
                end
            end
            OTPPS_PULSE: begin
                if (timer_done) begin
                    state_d = OTPPS_HOLD;
                end
            end
            OTPPS_HOLD: begin
                if (timer_done && pass_q == OTPPS_PASS_PROG) begin
                    state_d = OTPPS_NEXT;
                end else if (timer_done) begin
                    pulses_d = pulses_q + 4'h1;
                    state_d = OTPPS_VFY_OE;
                end
            end
            OTPPS_VFY_OE: begin
                if (timer_done) begin
                    state_d = OTPPS_VFY_FLOAT;
                end
            end
            OTPPS_VFY_FLOAT: begin
                // data pins reused only after the memory lets go
                if (timer_done) begin
                    if (match_q) begin
                        state_d = OTPPS_NEXT;
                    end else if (pass_q == OTPPS_PASS_FINAL) begin
                        fail_d = 1'b1;
                        state_d = OTPPS_NEXT;
                    end else if (pulses_used) begin
                        fail_d = 1'b1;
                        state_d = OTPPS_VPP_DOWN;
                        vpp_d = OTPPS_SUP_READ;
                    end else begin
                        state_d = OTPPS_SETUP;
                    end
                end
            end
            OTPPS_NEXT: begin
                if (!at_last) begin
                    addr_d = addr_q + 1'b1;
                    state_d = OTPPS_FETCH;
                end else if (pass_q == OTPPS_PASS_PROG) begin
                    addr_d = '0;
                    pass_d = OTPPS_PASS_VFY;
                    state_d = OTPPS_FETCH;
                end else if (pass_q == OTPPS_PASS_VFY) begin
                    state_d = OTPPS_VPP_DOWN;
                    vpp_d = OTPPS_SUP_READ;
                end else begin
                    state_d = OTPPS_FINISH;
                end
            end
            OTPPS_VPP_DOWN: begin
                if (timer_done) begin
                    state_d = OTPPS_VCC_DOWN;
                    vcc_d = OTPPS_SUP_READ;
                end
            end
            OTPPS_VCC_DOWN: begin
                if (timer_done && !fail_q && !id_mode_q &&
                        pass_q == OTPPS_PASS_VFY) begin
                    addr_d = '0;
                    pass_d = OTPPS_PASS_FINAL;
                    state_d = OTPPS_FETCH;
                end else if (timer_done) begin
                    state_d = OTPPS_FINISH;
                end
            end
            OTPPS_FINISH: begin
                done_d = 1'b1;
                state_d = OTPPS_IDLE;
            end
            OTPPS_ID_OE: begin
                if (timer_done) begin
                    state_d = OTPPS_ID_FLOAT;
                end
            end
            OTPPS_ID_FLOAT: begin
                if (timer_done) begin
                    state_d = OTPPS_VCC_DOWN;
                    vcc_d = OTPPS_SUP_READ;
                end
            end
            default: begin
                state_d = OTPPS_IDLE;
            end
        endcase
    end

    // pin levels follow the state being entered, so they change together
    wire drive_d = (state_d == OTPPS_SETUP) || (state_d == OTPPS_PULSE) ||
                   (state_d == OTPPS_HOLD);
    wire read_d = (state_d == OTPPS_VFY_OE) || (state_d == OTPPS_ID_OE);
    wire id_d = (state_d == OTPPS_ID_OE) || (state_d == OTPPS_ID_FLOAT);
    wire select_d = drive_d || read_d || id_d ||
                    (state_d == OTPPS_FETCH) || (state_d == OTPPS_NEXT) ||
                    (state_d == OTPPS_VFY_FLOAT);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= OTPPS_IDLE;
            pass_q <= OTPPS_PASS_NONE;
            vcc_q <= OTPPS_SUP_OFF;
            vpp_q <= OTPPS_SUP_OFF;
            addr_q <= '0;
            pulses_q <= '0;
            fail_q <= 1'b0;
            id_mode_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            pass_q <= pass_d;
            vcc_q <= vcc_d;
            vpp_q <= vpp_d;
            addr_q <= addr_d;
            pulses_q <= pulses_d;
            fail_q <= fail_d;
            id_mode_q <= id_mode_d;
            done_q <= done_d;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ce_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            pgm_n_q <= 1'b1;
            dq_oe_q <= 1'b0;
            hv_q <= 1'b0;
        end else begin
            ce_n_q <= !select_d;
            oe_n_q <= !read_d;
            pgm_n_q <= (state_d != OTPPS_PULSE);
            dq_oe_q <= drive_d;
            hv_q <= id_d;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            byte_q <= '0;
            match_q <= 1'b0;
            id_data_q <= '0;
            id_sel_q <= 1'b0;
        end else begin
            if (fetch_take) begin
                byte_q <= src_if.data;
            end
            if (sample_now) begin
                match_q <= byte_match;
            end
            if (sample_now && id_mode_q) begin
                id_data_q <= data_i_in;
            end
            if (state_q == OTPPS_IDLE && id_start_in) begin
                id_sel_q <= id_byte_select_in;
            end
        end
    end

    assign pass_out = pass_q;
    assign busy_out = (state_q != OTPPS_IDLE);
    assign done_out = done_q;
    assign result_pass_out = done_q && !fail_q && !id_mode_q;
    assign id_data_out = id_data_q;
    assign vcc_level_out = vcc_q;
    assign vpp_level_out = vpp_q;
    // identification drives all address lines low except the select bit
    assign addr_out = hv_q ? {{(`OTPPS_ADDR_W-1){1'b0}}, id_sel_q}
                           : addr_q;
    assign id_high_voltage_line_out = hv_q;
    assign chip_select_n_out = ce_n_q;
    assign output_enable_n_out = oe_n_q;
    assign program_strobe_n_out = pgm_n_q;
    assign data_o_out = byte_q;
    assign data_oe_out = dq_oe_q;
endmodule

// ---- otpps_checker.sv ----
// Purpose: pin timing checks of the sequencer
// Assumes: one clock domain, async active-low reset
// Notes: long waits are counted in helpers
`timescale 1ns/1ns
`include "otpps_defs.svh"
module otpps_checker
    import otpps_pkg::*;
#(
    parameter int PULSE_CYCLES = 20
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic start_in,
    input wire logic busy_out,
    input wire logic done_out,
    input wire otpps_pkg::otpps_supply_type vcc_level_out,
    input wire otpps_pkg::otpps_supply_type vpp_level_out,
    input wire logic [`OTPPS_ADDR_W-1:0] addr_out,
    input wire logic id_high_voltage_line_out,
    input wire logic chip_select_n_out,
    input wire logic output_enable_n_out,
    input wire logic program_strobe_n_out,
    input wire logic [`OTPPS_DATA_W-1:0] data_o_out,
    input wire logic data_oe_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    logic [15:0] low_q, stable_q, since_q;

    // stable_q and since_q saturate: a long idle never wraps into a pass
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            low_q <= 16'h0;
            stable_q <= 16'h0;
            since_q <= 16'h0;
        end else begin
            low_q <= program_strobe_n_out ? 16'h0 : low_q + 16'h1;
            if (!$stable({addr_out, data_o_out, data_oe_out,
                          chip_select_n_out, output_enable_n_out})) begin
                stable_q <= 16'h1;
            end else if (stable_q != 16'hFFFF) begin
                stable_q <= stable_q + 16'h1;
            end
            if ($rose(program_strobe_n_out)) begin
                since_q <= 16'h1;
            end else if (since_q != 16'hFFFF) begin
                since_q <= since_q + 16'h1;
            end
        end
    end

    sequence quiet8_seq;
        (!data_oe_out && output_enable_n_out)[*8];
    endsequence

    chk_supply_order: assert property (
        vpp_level_out != OTPPS_SUP_OFF |-> vcc_level_out != OTPPS_SUP_OFF &&
        (vpp_level_out != OTPPS_SUP_PROG || vcc_level_out == OTPPS_SUP_PROG))
        else $error("supply order");
    chk_pulse_supply: assert property (
        !program_strobe_n_out |-> vcc_level_out == OTPPS_SUP_PROG &&
        vpp_level_out == OTPPS_SUP_PROG)
        else $error("pulse levels");
    chk_pulse_width: assert property (
        $rose(program_strobe_n_out) |-> low_q == PULSE_CYCLES)
        else $error("pulse width");
    chk_pulse_mode: assert property (
        !program_strobe_n_out |-> !chip_select_n_out &&
        output_enable_n_out && data_oe_out)
        else $error("pulse mode");
    chk_pin_setup: assert property (
        $fell(program_strobe_n_out) |-> stable_q >= 500)
        else $error("pin setup");
    chk_data_hold: assert property (
        $fell(data_oe_out) |-> since_q >= 500)
        else $error("data hold");
    chk_verify_wait: assert property (
        $fell(output_enable_n_out) |->
        ##37 !output_enable_n_out ##1 output_enable_n_out)
        else $error("verify window");
    chk_float_wait: assert property (
        $rose(output_enable_n_out) |->
        quiet8_seq ##1 quiet8_seq ##1 quiet8_seq ##1 quiet8_seq)
        else $error("float wait");
    chk_no_contention: assert property (
        !output_enable_n_out |-> !data_oe_out)
        else $error("bus contention");
    chk_id_address: assert property (
        id_high_voltage_line_out |-> addr_out[`OTPPS_ADDR_W-1:1] == '0 &&
        vcc_level_out == OTPPS_SUP_PROG)
        else $error("id address");
    chk_start_busy: assert property (
        start_in && !busy_out |=> busy_out)
        else $error("start ignored");
    chk_done_levels: assert property (
        $rose(done_out) |-> !busy_out && vcc_level_out == OTPPS_SUP_READ &&
        vpp_level_out != OTPPS_SUP_PROG)
        else $error("done levels");
endmodule

bind otpps_sequencer otpps_checker #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .start_in(start_in),
    .busy_out(busy_out),
    .done_out(done_out),
    .vcc_level_out(vcc_level_out),
    .vpp_level_out(vpp_level_out),
    .addr_out(addr_out),
    .id_high_voltage_line_out(id_high_voltage_line_out),
    .chip_select_n_out(chip_select_n_out),
    .output_enable_n_out(output_enable_n_out),
    .program_strobe_n_out(program_strobe_n_out),
    .data_o_out(data_o_out),
    .data_oe_out(data_oe_out)
);

// ---- otpps_otp_model.sv ----
// Purpose: behavioural one-time-programmable byte memory
// Assumes: bench calls blank, sets need and bad_addr
// Notes: need pulses per byte force retries
`timescale 1ns/1ns
`include "otpps_defs.svh"
module otpps_otp_model
    import otpps_pkg::*;
#(
    parameter int LAST = 3,
    parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'hC3 // arbitrary value
) (
    input wire logic [`OTPPS_ADDR_W-1:0] addr_in,
    input wire logic hv_in,
    input wire logic cs_n_in,
    input wire logic oe_n_in,
    input wire logic strobe_n_in,
    input wire otpps_pkg::otpps_supply_type vcc_in,
    input wire otpps_pkg::otpps_supply_type vpp_in,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out
);
    logic [7:0] mem [0:LAST];
    int need [0:LAST];
    int pulses [0:LAST];
    int bad_addr;
    logic valid;
    logic [7:0] word_q;

    task automatic blank();
        for (int i = 0; i <= LAST; i++) begin
            mem[i] = 8'hFF;
            need[i] = 1;
            pulses[i] = 0;
        end
        bad_addr = -1;
    endtask

    initial begin
        blank();
        valid = 1'b0;
        word_q = 8'h00;
    end

    always @(posedge strobe_n_in) begin
        automatic int a = int'(addr_in) % (LAST + 1);
        if (!cs_n_in && oe_n_in && vcc_in == OTPPS_SUP_PROG &&
            vpp_in == OTPPS_SUP_PROG) begin
            pulses[a] = pulses[a] + 1;
            if (pulses[a] >= need[a]) begin
                mem[a] = mem[a] & data_in;
            end
        end
    end

    // byte valid only once the access time has run out
    always @(negedge oe_n_in) begin
        automatic int a = int'(addr_in) % (LAST + 1);
        valid = 1'b0;
        #150;
        if (!oe_n_in && !cs_n_in && strobe_n_in) begin
            word_q = mem[a];
            if (hv_in) begin
                word_q = addr_in[0] ? DEVICE_CODE : MAKER_CODE;
            end else if (vcc_in == OTPPS_SUP_READ && a == bad_addr) begin
                word_q = word_q ^ 8'h01;
            end
            valid = 1'b1;
        end
    end

    always @(posedge oe_n_in) begin
        valid = 1'b0;
    end

    // released pins invert the byte, never hold it
    assign data_out = valid ? word_q : ~word_q;
endmodule

// ---- otpps_sequencer_tb.sv ----
// Purpose: self-checking bench of the sequencer
// Assumes: four-byte array, 20-cycle pulse, for a short run
// Notes: each pass streams the same four bytes
`timescale 1ns/1ns
`include "otpps_defs.svh"
module otpps_sequencer_tb;
    import otpps_pkg::*;
    logic clk_in, rst_n_in, start_in, id_start_in, id_sel, src_valid_in;
    logic [7:0] src_data_in, id_data_out, data_o_out, mem_data, data_i;
    logic src_ready_out, busy_out, done_out, result_pass_out, hv;
    logic cs_n, oe_n, strobe_n, data_oe_out;
    logic [`OTPPS_ADDR_W-1:0] addr_out;
    otpps_supply_type vcc, vpp;
    logic [7:0] pat [4] = '{8'hA5, 8'h3C, 8'h00, 8'h7E};
    logic [7:0] feed_q [$];
    int error_cnt = 0, cmp_count = 0, cycles = 0;

    assign data_i = data_oe_out ? data_o_out : mem_data;

    otpps_sequencer #(.PULSE_CYCLES(20), .ADDR_LAST(18'h3)) uut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .start_in(start_in),
        .id_start_in(id_start_in), .id_byte_select_in(id_sel),
        .src_valid_in(src_valid_in), .src_ready_out(src_ready_out),
        .src_data_in(src_data_in), .pass_out(), .busy_out(busy_out),
        .done_out(done_out), .result_pass_out(result_pass_out),
        .id_data_out(id_data_out), .vcc_level_out(vcc),
        .vpp_level_out(vpp), .addr_out(addr_out),
        .id_high_voltage_line_out(hv), .chip_select_n_out(cs_n),
        .output_enable_n_out(oe_n), .program_strobe_n_out(strobe_n),
        .data_o_out(data_o_out), .data_oe_out(data_oe_out),
        .data_i_in(data_i));

    otpps_otp_model #(.LAST(3)) u_mem (
        .addr_in(addr_out), .hv_in(hv), .cs_n_in(cs_n), .oe_n_in(oe_n),
        .strobe_n_in(strobe_n), .vcc_in(vcc), .vpp_in(vpp),
        .data_in(data_o_out), .data_out(mem_data));

    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        if (src_valid_in && src_ready_out) void'(feed_q.pop_front());
        #1;
        src_valid_in = feed_q.size() > 0;
        src_data_in = (feed_q.size() > 0) ? feed_q[0] : 8'h00;
        cycles++;
        if (cycles == 90000) begin
            error_cnt++;
            $display("unexpected at %0t: run too long", $time);
            finish_test();
        end
    end

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: flag %b want %b", $time, got, exp);
        end
    endtask

    task automatic do_reset();
        rst_n_in = 1'b0;
        feed_q.delete();
        repeat (6) @(posedge clk_in);
        #1 rst_n_in = 1'b1;
    endtask

    task automatic wait_done();
        int n = 0;
        @(posedge clk_in);
        #1 start_in = 1'b0;
        id_start_in = 1'b0;
        while (done_out !== 1'b1 && n < 30000) begin
            @(posedge clk_in);
            n++;
        end
        #1 check_flag(done_out, 1'b1);
    endtask

    // three passes of bytes; a full buffer refuses more
    task automatic prog_run(input logic exp_pass);
        for (int p = 0; p < 3; p++)
            for (int i = 0; i < 4; i++) feed_q.push_back(pat[i]);
        repeat (8) @(posedge clk_in);
        #1 check_flag(src_ready_out, 1'b0);
        start_in = 1'b1;
        wait_done();
        check_flag(result_pass_out, exp_pass);
        check_byte({6'h0, vcc}, 8'h01);
        check_byte({6'h0, vpp}, 8'h01);
    endtask

    task automatic s_clean();
        u_mem.blank();
        prog_run(1'b1);
        for (int i = 0; i < 4; i++) begin
            check_byte(8'(u_mem.pulses[i]), 8'h01);
            check_byte(u_mem.mem[i], pat[i]);
        end
        check_byte(8'(feed_q.size()), 8'h00);
    endtask

    task automatic s_retry();
        u_mem.blank();
        u_mem.need[2] = 11;
        prog_run(1'b1);
        check_byte(8'(u_mem.pulses[2]), 8'h0B);
        check_byte(8'(u_mem.pulses[3]), 8'h01);
    endtask

    task automatic s_fail();
        u_mem.blank();
        u_mem.need[1] = 12;
        prog_run(1'b0);
        check_byte(8'(u_mem.pulses[1]), 8'h0B);
        check_byte(8'(u_mem.pulses[2]), 8'h01);
        check_byte(8'(uut.pass_out), 8'h02);
        do_reset();
    endtask

    task automatic s_final();
        u_mem.blank();
        u_mem.bad_addr = 3;
        prog_run(1'b0);
        check_byte(8'(u_mem.pulses[3]), 8'h01);
    endtask

    task automatic s_ident();
        for (int s = 0; s < 2; s++) begin
            id_sel = s[0];
            id_start_in = 1'b1;
            wait_done();
            check_byte(id_data_out, s ? 8'hC3 : 8'h5A);
            check_flag(result_pass_out, 1'b0);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        start_in = 1'b0;
        id_start_in = 1'b0;
        id_sel = 1'b0;
        src_valid_in = 1'b0;
        do_reset();
        s_clean();
        s_retry();
        s_fail();
        s_final();
        s_ident();
        finish_test();
    end
endmodule
